// ---- verilog/jtx_dev_end.sv ----
// lane test-pattern transmitter with its configuration registers and lane fifo
`timescale 1ns/100ps
`default_nettype none

module jtx_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_q != rd_q;
   assign out_data_o  = mem_q[rd_q[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

module jtx_dev_end (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   jtx_if.dev               link,
   input  wire logic [15:0] sample_i,
   input  wire logic        sample_valid_i,
   output logic             sample_ready_o
);
   logic [4:0]  test_q;
   logic [6:0]  ident_q;
   logic [1:0]  comma_q;
   logic [7:0]  rdata_q;
   logic        ack_q;
   logic [30:0] prbs_q;
   logic [30:0] prbs_d;
   logic [7:0]  ramp_q;
   logic [3:0]  pos_q;
   logic [1:0]  mf_q;
   logic [15:0] prev_q;
   logic [17:0] word_d;
   logic        gen_valid;
   logic        gen_ready;
   logic        fire;
   logic [7:0]  ident_a;
   logic [7:0]  ident_b;
   logic [7:0]  comma_ch;

   // advance the generator eight bits for the selected polynomial
   function automatic logic [30:0] prbs_step(input logic [30:0] s, input logic [4:0] sel);
      logic [30:0] r;
      logic        fb;
      r = s;
      for (int i = 0; i < 8; i++) begin
         case (sel)
            jtx_pkg::TP_PRBS7:  fb = r[6] ^ r[5];
            jtx_pkg::TP_PRBS9:  fb = r[8] ^ r[4];
            jtx_pkg::TP_PRBS15: fb = r[14] ^ r[13];
            jtx_pkg::TP_PRBS23: fb = r[22] ^ r[17];
            default:            fb = r[30] ^ r[27];
         endcase
         r = {r[29:0], fb};
      end
      return r;
   endfunction

   // one octet of the alignment sequence: {k, octet}
   function automatic logic [8:0] ila_octet(input logic [3:0] pos, input logic [1:0] mf,
                                            input logic [7:0] ident);
      logic [8:0] o;
      o = {1'b0, 4'h0, pos};
      if (pos == 4'h0) begin
         o = {1'b1, jtx_pkg::CH_K28_0};
      end else if (pos == jtx_pkg::MF_LAST) begin
         o = {1'b1, jtx_pkg::CH_K28_3};
      end else if (mf == 2'h1 && pos == 4'h1) begin
         o = {1'b1, jtx_pkg::CH_K28_4};
      end else if (mf == 2'h1 && pos == 4'h2) begin
         o = {1'b0, ident};
      end
      return o;
   endfunction

   // short jitter-stress octet table, cycled along the multiframe
   function automatic logic [7:0] rpat_octet(input logic [2:0] idx);
      case (idx)
         3'h0:    return 8'hBE;
         3'h1:    return 8'hD7;
         3'h2:    return 8'h23;
         3'h3:    return 8'h47;
         3'h4:    return 8'h6B;
         3'h5:    return 8'h8F;
         3'h6:    return 8'hB3;
         default: return 8'h14;
      endcase
   endfunction

   // settings are written only while the link is idle, so no shadowing is kept
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         test_q  <= jtx_pkg::TEST_RST;
         ident_q <= jtx_pkg::IDENT_RST;
         comma_q <= jtx_pkg::COMMA_RST;
      end else if (link.cfg_wr && !ack_q) begin
         case (link.cfg_addr)
            jtx_pkg::TEST_OFS:  test_q  <= link.cfg_wdata[jtx_pkg::TEST_MSB:0];
            jtx_pkg::IDENT_OFS: ident_q <= link.cfg_wdata[7:1];
            jtx_pkg::COMMA_OFS: comma_q <= link.cfg_wdata[jtx_pkg::COMMA_MSB:0];
            default:            test_q  <= test_q;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= (link.cfg_wr || link.cfg_rd) && !ack_q;
         case (link.cfg_addr)
            jtx_pkg::TEST_OFS:  rdata_q <= {3'h0, test_q};
            jtx_pkg::IDENT_OFS: rdata_q <= {ident_q, 1'b0};
            jtx_pkg::COMMA_OFS: rdata_q <= {6'h00, comma_q};
            default:            rdata_q <= 8'h00;
         endcase
      end
   end

   assign link.cfg_ack   = ack_q;
   assign link.cfg_rdata = rdata_q;

   // link B carries identifier plus one
   assign ident_a = {ident_q, 1'b0};
   assign ident_b = {ident_q, 1'b1};

   // comma choice, reserved falls back to K28.7
   always_comb begin
      case (comma_q)
         2'h1:    comma_ch = jtx_pkg::CH_K28_1;
         2'h2:    comma_ch = jtx_pkg::CH_K28_5;
         default: comma_ch = jtx_pkg::CH_K28_7;
      endcase
   end

   assign prbs_d         = prbs_step(prbs_q, test_q);
   assign gen_valid      = link.link_enable && (test_q != jtx_pkg::TP_NORMAL || sample_valid_i);
   assign fire           = gen_valid && gen_ready;
   assign sample_ready_o = link.link_enable && test_q == jtx_pkg::TP_NORMAL && gen_ready;

   always_comb begin
      word_d = '0;
      case (test_q)
         // sample data, two octets per frame
         jtx_pkg::TP_NORMAL: begin
            word_d = {1'b0, sample_i[15:8], 1'b0, sample_i[7:0]};
            // end-of-frame octet repeated from last frame becomes the comma
            if (link.mode_8b10b && pos_q[0]) begin
               if (sample_i[7:0] == prev_q[7:0]) begin
                  word_d[8:0] = {1'b1, comma_ch};
               end
               if (sample_i[15:8] == prev_q[15:8]) begin
                  word_d[17:9] = {1'b1, comma_ch};
               end
            end
         end
         jtx_pkg::TP_PRBS7, jtx_pkg::TP_PRBS15, jtx_pkg::TP_PRBS23,
         jtx_pkg::TP_PRBS9, jtx_pkg::TP_PRBS31:
            word_d = {1'b0, prbs_d[7:0], 1'b0, prbs_d[7:0]};
         jtx_pkg::TP_RAMP:      word_d = {1'b0, ramp_q, 1'b0, ramp_q};
         jtx_pkg::TP_TRANSPORT: word_d = {1'b0, ~{mf_q, 2'h0, pos_q}, 1'b0, {mf_q, 2'h0, pos_q}};
         jtx_pkg::TP_D21_5: word_d = {1'b0, jtx_pkg::CH_D21_5, 1'b0, jtx_pkg::CH_D21_5};
         jtx_pkg::TP_K28_5: word_d = {1'b1, jtx_pkg::CH_K28_5, 1'b1, jtx_pkg::CH_K28_5};
         jtx_pkg::TP_K28_7: word_d = {1'b1, jtx_pkg::CH_K28_7, 1'b1, jtx_pkg::CH_K28_7};
         // looping alignment sequence, identifier in multiframe one
         jtx_pkg::TP_ILA: word_d = {ila_octet(pos_q, mf_q, ident_b),
                                    ila_octet(pos_q, mf_q, ident_a)};
         jtx_pkg::TP_RPAT: word_d = {1'b0, rpat_octet(pos_q[2:0]), 1'b0, rpat_octet(pos_q[2:0])};
         jtx_pkg::TP_LOW:  word_d = {1'b0, 8'h00, 1'b0, 8'h00};
         jtx_pkg::TP_HIGH: word_d = {1'b0, 8'hFF, 1'b0, 8'hFF};
         jtx_pkg::TP_CLOCK: begin
            if (pos_q[0]) begin
               word_d = {1'b0, jtx_pkg::CLK_HI, 1'b0, jtx_pkg::CLK_HI};
            end else begin
               word_d = {1'b0, jtx_pkg::CLK_LO, 1'b0, jtx_pkg::CLK_LO};
            end
         end
         default: word_d = '0;
      endcase
   end

   // generators restart whenever the link is disabled, so every run starts aligned
   always_ff @(posedge clk_i) begin
      if (rst_i || !link.link_enable) begin
         prbs_q <= jtx_pkg::PRBS_SEED;
         ramp_q <= 8'h00;
         pos_q  <= 4'h0;
         mf_q   <= 2'h0;
         prev_q <= 16'h0000;
      end else if (fire) begin
         prbs_q <= prbs_d;
         ramp_q <= ramp_q + 8'h01;
         pos_q  <= pos_q + 4'h1;
         if (pos_q == jtx_pkg::MF_LAST) begin
            mf_q <= mf_q + 2'h1;
         end
         if (pos_q[0]) begin
            prev_q <= sample_i;
         end
      end
   end

   jtx_fifo #(
      .WIDTH (jtx_pkg::LANE_W),
      .DEPTH (jtx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (word_d),
      .in_valid_i  (gen_valid),
      .in_ready_o  (gen_ready),
      .out_data_o  (link.lane_data),
      .out_valid_o (link.lane_valid),
      .out_ready_i (link.lane_ready)
   );
endmodule
`default_nettype wire

// ---- verilog/jtx_pkg.sv ----
// shared constants for the lane test-pattern transmitter and its configuring end
package jtx_pkg;
   // device configuration space
   localparam logic [9:0]  TEST_OFS       = 10'h205;
   localparam logic [9:0]  IDENT_OFS      = 10'h206;
   localparam logic [9:0]  COMMA_OFS      = 10'h207;
   localparam logic [4:0]  TEST_RST       = 5'h00;
   localparam logic [6:0]  IDENT_RST      = 7'h00;
   localparam logic [1:0]  COMMA_RST      = 2'h0;
   localparam int          TEST_MSB       = 4;
   localparam int          COMMA_MSB      = 1;

   // test pattern select codes
   localparam logic [4:0]  TP_NORMAL      = 5'h00;
   localparam logic [4:0]  TP_PRBS7       = 5'h01;
   localparam logic [4:0]  TP_PRBS15      = 5'h02;
   localparam logic [4:0]  TP_PRBS23      = 5'h03;
   localparam logic [4:0]  TP_RAMP        = 5'h04;
   localparam logic [4:0]  TP_TRANSPORT   = 5'h05;
   localparam logic [4:0]  TP_D21_5       = 5'h06;
   localparam logic [4:0]  TP_K28_5       = 5'h07;
   localparam logic [4:0]  TP_ILA         = 5'h08;
   localparam logic [4:0]  TP_RPAT        = 5'h09;
   localparam logic [4:0]  TP_LOW         = 5'h0A;
   localparam logic [4:0]  TP_HIGH        = 5'h0B;
   localparam logic [4:0]  TP_RSVD12      = 5'h0C;
   localparam logic [4:0]  TP_PRBS9       = 5'h0D;
   localparam logic [4:0]  TP_PRBS31      = 5'h0E;
   localparam logic [4:0]  TP_CLOCK       = 5'h0F;
   localparam logic [4:0]  TP_K28_7       = 5'h10;

   // octet values of the 8b/10b characters in use
   localparam logic [7:0]  CH_K28_0       = 8'h1C;
   localparam logic [7:0]  CH_K28_1       = 8'h3C;
   localparam logic [7:0]  CH_K28_3       = 8'h7C;
   localparam logic [7:0]  CH_K28_4       = 8'h9C;
   localparam logic [7:0]  CH_K28_5       = 8'hBC;
   localparam logic [7:0]  CH_K28_7       = 8'hFC;
   localparam logic [7:0]  CH_D21_5       = 8'hB5;
   localparam logic [7:0]  CLK_LO         = 8'h00;
   localparam logic [7:0]  CLK_HI         = 8'hFF;
   localparam logic [30:0] PRBS_SEED      = 31'h7FFFFFFF;

   // lane word: {k_b, octet_b, k_a, octet_a}
   localparam int          LANE_W         = 18;
   localparam int          FIFO_DEPTH     = 8;
   localparam logic [3:0]  MF_LAST        = 4'hF;

   // controller registers, byte addresses on the wishbone side
   localparam logic [7:0]  H_CTRL_ADR     = 8'h00;
   localparam logic [7:0]  H_CMD_ADR      = 8'h04;
   localparam logic [7:0]  H_STAT_ADR     = 8'h08;
   localparam logic [7:0]  H_RX_ADR       = 8'h0C;
   localparam logic [7:0]  H_CNT_ADR      = 8'h10;
   localparam int          CTRL_EN_BIT    = 0;
   localparam int          CTRL_8B10B_BIT = 1;
   localparam int          CTRL_DRAIN_BIT = 2;
   localparam int          CMD_WR_BIT     = 24;
   localparam logic [2:0]  CTRL_RST       = 3'h2;
endpackage

// ---- verilog/jtx_if.sv ----
// link between the configuring end and the pattern transmitter
`timescale 1ns/100ps
`default_nettype none
interface jtx_if;
   logic [9:0]  cfg_addr;
   logic [7:0]  cfg_wdata;
   logic        cfg_wr;
   logic        cfg_rd;
   logic [7:0]  cfg_rdata;
   logic        cfg_ack;
   logic        link_enable;
   logic        mode_8b10b;
   logic [17:0] lane_data;
   logic        lane_valid;
   logic        lane_ready;

   modport dev (
      input  cfg_addr, cfg_wdata, cfg_wr, cfg_rd, link_enable, mode_8b10b, lane_ready,
      output cfg_rdata, cfg_ack, lane_data, lane_valid
   );
   modport host (
      output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, link_enable, mode_8b10b, lane_ready,
      input  cfg_rdata, cfg_ack, lane_data, lane_valid
   );
endinterface
`default_nettype wire

// ---- verilog/jtx_host_end.sv ----
// configuring end: wishbone registers, guarded configuration access and lane capture
`timescale 1ns/100ps
`default_nettype none
module jtx_host_end (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   jtx_if.host              link,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);
   typedef enum logic [0:0] {
      JTX_IDLE = 1'b0,
      JTX_BUSY = 1'b1
   } jtx_state_e;

   jtx_state_e  state_q;
   logic [2:0]  ctrl_q;
   logic [9:0]  addr_q;
   logic [7:0]  wdata_q;
   logic        wr_q;
   logic [7:0]  rback_q;
   logic        refused_q;
   logic [17:0] rx_q;
   logic [31:0] cnt_q;
   logic        ack_q;
   logic [31:0] dat_q;
   logic        wb_req;
   logic        cmd_go;
   logic        bad_code;
   logic [4:0]  code;

   assign wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
   assign cmd_go   = wb_req && wb_we_i && wb_adr_i == jtx_pkg::H_CMD_ADR && wb_sel_i[3];
   assign code     = wb_dat_i[4:0];

   // reserved codes and bits above the field refused
   always_comb begin
      bad_code = wb_dat_i[7:5] != 3'h0 || code == jtx_pkg::TP_RSVD12 || code > jtx_pkg::TP_K28_7;
      if (!ctrl_q[jtx_pkg::CTRL_8B10B_BIT] && (code == jtx_pkg::TP_K28_5 ||
          code == jtx_pkg::TP_ILA || code == jtx_pkg::TP_RPAT || code == jtx_pkg::TP_K28_7)) begin
         bad_code = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= jtx_pkg::CTRL_RST;
      end else if (wb_req && wb_we_i && wb_adr_i == jtx_pkg::H_CTRL_ADR && wb_sel_i[0]) begin
         ctrl_q <= wb_dat_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= JTX_IDLE;
         addr_q    <= 10'h000;
         wdata_q   <= 8'h00;
         wr_q      <= 1'b0;
         rback_q   <= 8'h00;
         refused_q <= 1'b0;
      end else begin
         case (state_q)
            JTX_IDLE: begin
               if (cmd_go) begin
                  // no configuration access while the link runs
                  if (ctrl_q[jtx_pkg::CTRL_EN_BIT] || (wb_dat_i[jtx_pkg::CMD_WR_BIT] &&
                      wb_dat_i[17:8] == jtx_pkg::TEST_OFS && bad_code)) begin
                     refused_q <= 1'b1;
                  end else begin
                     refused_q <= 1'b0;
                     addr_q    <= wb_dat_i[17:8];
                     wdata_q   <= wb_dat_i[7:0];
                     wr_q      <= wb_dat_i[jtx_pkg::CMD_WR_BIT];
                     state_q   <= JTX_BUSY;
                  end
               end
            end
            JTX_BUSY: begin
               if (link.cfg_ack) begin
                  rback_q <= link.cfg_rdata;
                  state_q <= JTX_IDLE;
               end
            end
            default: state_q <= JTX_IDLE;
         endcase
      end
   end

   assign link.cfg_addr    = addr_q;
   assign link.cfg_wdata   = wdata_q;
   assign link.cfg_wr      = state_q == JTX_BUSY && wr_q;
   assign link.cfg_rd      = state_q == JTX_BUSY && !wr_q;
   assign link.link_enable = ctrl_q[jtx_pkg::CTRL_EN_BIT];
   assign link.mode_8b10b  = ctrl_q[jtx_pkg::CTRL_8B10B_BIT];
   // software can stall the drain so the lane fifo really fills
   assign link.lane_ready  = ctrl_q[jtx_pkg::CTRL_DRAIN_BIT];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_q  <= 18'h00000;
         cnt_q <= 32'h00000000;
      end else if (link.lane_valid && link.lane_ready) begin
         rx_q  <= link.lane_data;
         cnt_q <= cnt_q + 32'h00000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_req;
         case (wb_adr_i)
            jtx_pkg::H_CTRL_ADR: dat_q <= {29'h0, ctrl_q};
            jtx_pkg::H_CMD_ADR:  dat_q <= {7'h0, wr_q, 6'h0, addr_q, wdata_q};
            jtx_pkg::H_STAT_ADR: dat_q <= {16'h0, rback_q, 6'h0, refused_q, state_q == JTX_BUSY};
            jtx_pkg::H_RX_ADR:   dat_q <= {14'h0, rx_q};
            jtx_pkg::H_CNT_ADR:  dat_q <= cnt_q;
            default:             dat_q <= 32'h00000000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
endmodule
`default_nettype wire

// ---- test/jtx_chk_sva.sv ----
// link checks between the configuring end and the pattern transmitter
`timescale 1ns/100ps
`default_nettype none
module jtx_chk_sva (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [9:0]  cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_rdata,
   input  wire logic        cfg_ack,
   input  wire logic        link_enable,
   input  wire logic        mode_8b10b,
   input  wire logic [17:0] lane_data,
   input  wire logic        lane_valid,
   input  wire logic        lane_ready
);
   logic [4:0]  pat_q;
   logic [6:0]  id_q;
   logic        cln_q;
   logic [17:0] fix;
   logic        acc;
   logic        wok;
   logic        tst;
   assign acc = lane_valid && lane_ready;
   assign wok = cfg_wr && cfg_ack;
   assign tst = cfg_addr == jtx_pkg::TEST_OFS;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // words queued under an older pattern are not judged
   always_ff @(posedge clk_i) begin
      if (rst_i || (wok && tst)) begin
         cln_q <= 1'b0;
      end else if (!lane_valid) begin
         cln_q <= 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pat_q <= 5'h00;
         id_q  <= 7'h00;
      end else if (wok && tst) begin
         pat_q <= cfg_wdata[4:0];
      end else if (wok && cfg_addr == jtx_pkg::IDENT_OFS) begin
         id_q <= cfg_wdata[7:1];
      end
   end
   // all ones marks a pattern without one fixed word
   always_comb begin
      case (pat_q)
         5'h06:   fix = {1'b0, 8'hB5, 1'b0, 8'hB5};
         5'h07:   fix = {1'b1, 8'hBC, 1'b1, 8'hBC};
         5'h10:   fix = {1'b1, 8'hFC, 1'b1, 8'hFC};
         5'h0A:   fix = 18'h00000;
         5'h0B:   fix = {1'b0, 8'hFF, 1'b0, 8'hFF};
         default: fix = 18'h3FFFF;
      endcase
   end
   sequence pair_s(logic [4:0] code);
      acc && cln_q && pat_q == code ##1 acc;
   endsequence
   sequence ila_s;
      acc && cln_q && pat_q == 5'h08 && lane_data[8:0] == 9'h19C ##1 acc;
   endsequence
   AST_CFG_HOLD: assert property (cfg_wr && !cfg_ack |=> cfg_wr && $stable(cfg_addr))
      else $error("config request dropped early");
   AST_CFG_ACK: assert property ($rose(cfg_wr || cfg_rd) |-> ##1 cfg_ack)
      else $error("config request not answered");
   AST_CFG_LOCK: assert property (cfg_wr |-> !link_enable)
      else $error("config write with link on");
   AST_CHAR_MODE: assert property (cfg_wr && tst && !mode_8b10b
      |-> !(cfg_wdata[4:0] inside {5'h07, 5'h08, 5'h09, 5'h10}))
      else $error("character mode outside 8b10b");
   AST_NO_RSVD: assert property (cfg_wr && tst
      |-> cfg_wdata[7:5] == 3'h0 && cfg_wdata[4:0] != 5'h0C && cfg_wdata[4:0] <= 5'h10)
      else $error("reserved pattern written");
   AST_ID_EVEN: assert property (cfg_rd && cfg_ack && cfg_addr == jtx_pkg::IDENT_OFS
      |-> !cfg_rdata[0])
      else $error("identifier bit zero set");
   AST_FIXED: assert property (acc && cln_q && fix != 18'h3FFFF |-> lane_data == fix)
      else $error("fixed pattern word wrong");
   AST_CLOCK: assert property (pair_s(5'h0F)
      |-> lane_data[7:0] == ~$past(lane_data[7:0]) && lane_data[16:9] == lane_data[7:0])
      else $error("clock pattern wrong");
   AST_RAMP: assert property (pair_s(5'h04)
      |-> lane_data[7:0] == $past(lane_data[7:0]) + 8'h01)
      else $error("ramp step wrong");
   AST_PRBS: assert property (acc && cln_q && pat_q inside {5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E}
      |-> lane_data[16:9] == lane_data[7:0] && !lane_data[17] && !lane_data[8])
      else $error("prbs lanes differ");
   AST_ILA_ID: assert property (ila_s
      |-> lane_data == {1'b0, id_q, 1'b1, 1'b0, id_q, 1'b0})
      else $error("alignment identifier wrong");
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench: both ends joined over their link, run from wishbone
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_i;
   logic        rst_i;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [3:0]  wb_sel_i;
   logic        wb_we_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [15:0] sample_i;
   logic        sample_valid_i;
   logic        sample_ready_o;
   logic        cap_on;
   logic [17:0] cap_q[$];
   logic [31:0] st;
   int          err_total;
   int          total_checks;
   int          n_acc;
   jtx_if lnk ();
   jtx_dev_end i_jtx_dev_end (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .sample_i(sample_i),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o));
   jtx_host_end i_jtx_host_end (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   jtx_chk_sva i_jtx_chk_sva (.clk_i(clk_i), .rst_i(rst_i), .cfg_addr(lnk.cfg_addr),
      .cfg_wdata(lnk.cfg_wdata), .cfg_wr(lnk.cfg_wr), .cfg_rd(lnk.cfg_rd),
      .cfg_rdata(lnk.cfg_rdata), .cfg_ack(lnk.cfg_ack), .link_enable(lnk.link_enable),
      .mode_8b10b(lnk.mode_8b10b), .lane_data(lnk.lane_data), .lane_valid(lnk.lane_valid),
      .lane_ready(lnk.lane_ready));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (cap_on && lnk.lane_valid && lnk.lane_ready) begin
         cap_q.push_back(lnk.lane_data);
      end
      if (sample_valid_i && sample_ready_o) begin
         n_acc++;
      end
   end
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_lane(input string nm, input logic [17:0] e, input logic [17:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // holds the request until ack is sampled; read data lands in st
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n = 0;
      @(posedge clk_i);
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_we_i  <= we;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      st = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk_reg("wishbone ack", 32'h1, {31'h0, wb_ack_o});
   endtask
   task automatic ctl(input logic [2:0] c);
      wb(1'b1, jtx_pkg::H_CTRL_ADR, {29'h0, c});
   endtask
   task automatic dev(input logic we, input logic [9:0] a, input logic [7:0] d);
      int n = 0;
      wb(1'b1, jtx_pkg::H_CMD_ADR, {7'h00, we, 6'h00, a, d});
      do begin
         wb(1'b0, jtx_pkg::H_STAT_ADR, 32'h0);
         n++;
      end while (st[0] !== 1'b0 && n < 20);
      if (st[0] !== 1'b0) err_total++;
   endtask
   task automatic wait_idle();
      int n = 0;
      while (lnk.lane_valid !== 1'b0 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (lnk.lane_valid !== 1'b0) err_total++;
   endtask
   task automatic run_pat(input logic [4:0] code, input logic [2:0] c, input int nw);
      int n = 0;
      ctl(c);
      wait_idle();
      dev(1'b1, jtx_pkg::TEST_OFS, {3'h0, code});
      chk_reg("accepted", 32'h0, {31'h0, st[1]});
      cap_q.delete();
      cap_on = 1'b1;
      ctl(c | 3'h1);
      while (cap_q.size() < nw && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      if (cap_q.size() < nw) err_total++;
      cap_on = 1'b0;
      ctl(c);
   endtask
   task automatic t_reset();
      wb(1'b0, jtx_pkg::H_CTRL_ADR, 32'h0);
      chk_reg("ctrl", {29'h0, jtx_pkg::CTRL_RST}, st);
      wb(1'b1, 8'h14, 32'hFFFFFFFF);
      wb(1'b0, 8'h14, 32'h0);
      chk_reg("unmapped", 32'h0, st);
      dev(1'b0, jtx_pkg::TEST_OFS, 8'h00);
      chk_reg("pattern", 32'h0, {24'h0, st[15:8]});
      dev(1'b0, jtx_pkg::IDENT_OFS, 8'h00);
      chk_reg("identifier", 32'h0, {24'h0, st[15:8]});
      dev(1'b0, jtx_pkg::COMMA_OFS, 8'h00);
      chk_reg("comma", 32'h0, {24'h0, st[15:8]});
   endtask
   // fill with the far side stalled, then drain
   task automatic t_fifo();
      ctl(3'h0);
      n_acc = 0;
      ctl(3'h1);
      repeat (jtx_pkg::FIFO_DEPTH + 6) @(posedge clk_i);
      chk_reg("samples taken", jtx_pkg::FIFO_DEPTH, n_acc);
      chk_reg("sample ready", 32'h0, {31'h0, sample_ready_o});
      ctl(3'h4);
      wait_idle();
      wb(1'b0, jtx_pkg::H_CNT_ADR, 32'h0);
      chk_reg("count", jtx_pkg::FIFO_DEPTH, st);
      wb(1'b0, jtx_pkg::H_RX_ADR, 32'h0);
      chk_reg("last word", {14'h0, 18'h14A5A}, st);
   endtask
   task automatic t_ident();
      dev(1'b1, jtx_pkg::IDENT_OFS, 8'h35);
      dev(1'b0, jtx_pkg::IDENT_OFS, 8'h00);
      chk_reg("identifier", 32'h34, {24'h0, st[15:8]});
      run_pat(5'h08, 3'h6, 20);
      chk_lane("ila start", {1'b1, 8'h1C, 1'b1, 8'h1C}, cap_q[0]);
      chk_lane("ila ident", {1'b0, 8'h35, 1'b0, 8'h34}, cap_q[18]);
   endtask
   task automatic t_fixed();
      logic [4:0] cd[6] = '{5'h06, 5'h07, 5'h0A, 5'h0B, 5'h10, 5'h0F};
      logic [8:0] ch[6] = '{9'h0B5, 9'h1BC, 9'h000, 9'h0FF, 9'h1FC, 9'h000};
      for (int i = 0; i < 6; i++) begin
         run_pat(cd[i], 3'h6, 4);
         chk_lane("fixed word", {ch[i], ch[i]}, cap_q[2]);
      end
   endtask
   task automatic t_seq();
      logic [4:0] cd[6] = '{5'h01, 5'h02, 5'h03, 5'h0D, 5'h0E, 5'h04};
      for (int i = 0; i < 6; i++) begin
         run_pat(cd[i], 3'h6, 4);
         if (i == 0) chk_lane("prbs7", {1'b0, 8'h02, 1'b0, 8'h02}, cap_q[0]);
      end
      run_pat(5'h05, 3'h6, 4);
      chk_lane("transport", {1'b0, 8'hFC, 1'b0, 8'h03}, cap_q[3]);
      run_pat(5'h09, 3'h6, 4);
      chk_lane("rpat", 18'h000BE, {10'h0, cap_q[0][7:0]});
   endtask
   task automatic t_comma();
      logic [7:0] ch[4] = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
      run_pat(5'h00, 3'h4, 4);
      chk_lane("no comma", 18'h14A5A, cap_q[3]);
      for (int i = 0; i < 4; i++) begin
         dev(1'b1, jtx_pkg::COMMA_OFS, 8'(i));
         run_pat(5'h00, 3'h6, 4);
         chk_lane("frame comma", {1'b1, ch[i], 1'b1, ch[i]}, cap_q[3]);
      end
   endtask
   task automatic t_refuse();
      logic [7:0] cd[3] = '{8'h07, 8'h0C, 8'h31};
      ctl(3'h4);
      for (int i = 0; i < 3; i++) begin
         dev(1'b1, jtx_pkg::TEST_OFS, cd[i]);
         chk_reg("refused", 32'h1, {31'h0, st[1]});
      end
      ctl(3'h5);
      dev(1'b1, jtx_pkg::IDENT_OFS, 8'h08);
      chk_reg("refused", 32'h1, {31'h0, st[1]});
      ctl(3'h4);
      dev(1'b0, jtx_pkg::IDENT_OFS, 8'h00);
      chk_reg("identifier", 32'h34, {24'h0, st[15:8]});
      dev(1'b0, jtx_pkg::TEST_OFS, 8'h00);
      chk_reg("pattern", 32'h0, {24'h0, st[15:8]});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      err_total++;
      results();
   end
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
      sample_i = 16'hA55A;
      sample_valid_i = 1'b1;
      cap_on = 1'b0;
      err_total = 0;
      total_checks = 0;
      n_acc = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_fifo();
      t_ident();
      t_fixed();
      t_seq();
      t_comma();
      t_refuse();
      results();
   end
endmodule
`default_nettype wire
